/* File: bench/acf_host_model.sv */
`timescale 1ns/10ps
module acf_host_model import acf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic clr_i,
  input wire logic valid_i,
  input wire logic [WORD_WIDTH-1:0] word_i,
  output logic ready_o,
  output logic [WORD_WIDTH-1:0] last_q,
  output int run_q,
  output int max_run_q,
  output int taken_q
);
  // Receiver stalls on request, so the buffer must hold
  assign ready_o = !stall_i;
  // Capture words, track longest run of repeated words
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      last_q <= '0;
      run_q <= 0;
      max_run_q <= 0;
      taken_q <= 0;
    end else if (valid_i && ready_o) begin
      taken_q <= taken_q + 1;
      last_q <= word_i;
      run_q <= (word_i === last_q) ? run_q + 1 : 1;
      if ((word_i === last_q) && run_q + 1 > max_run_q) begin
        max_run_q <= run_q + 1;
      end
    end
  end
endmodule

/* File: bench/acf_top_test.sv */
`timescale 1ns/10ps
module acf_top_test import acf_pkg::*;;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic wb_ack_o, cal_restart_i = 0, chip_enable_n_i = 1, output_enable_n_i = 1, cal_pulse_i = 0;
  logic conv_valid_i = 0, conv_ready_o, comparator_busy_o, sample_word_oe_o, sample_valid_o, sample_ready_i;
  logic [9:0] conv_code_i = '0, sample_word_out_o, last_q;
  logic sample_unusable_o, sample_low_unreliable_o, stall = 1, clr = 0, feed = 0;
  int bad_count = 0, n_tests = 0, busy_n = 0, acc_n = 0, run_q, max_run_q, taken_q;

  acf_top #(.STARTUP_CYCLES(20)) dut (.*);
  acf_host_model host (.clk_i, .rst_i, .stall_i(stall), .clr_i(clr), .valid_i(sample_valid_o),
    .word_i(sample_word_out_o), .ready_o(sample_ready_i), .last_q, .run_q, .max_run_q, .taken_q);

  // Clock at 100 MHz
  always #5 clk_i = !clk_i;
  // Free-running feeder advances the code on every accepted sample
  always @(posedge clk_i) begin
    if (comparator_busy_o === 1'b1) busy_n++;
    if (feed && conv_ready_o === 1'b1) begin
      acc_n++;
      conv_code_i <= conv_code_i + 10'h001;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Hold the request until ack is seen; only the watchdog ends a hang
    do begin @(posedge clk_i); end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask

  // Push one code with the receiver stalled, then check the word
  task automatic push(input logic [9:0] code, input logic [9:0] exp);
    int i;
    conv_valid_i <= 1;
    conv_code_i <= code;
    i = 0;
    do begin @(posedge clk_i); i++; end while (conv_ready_o !== 1'b1 && i < 50);
    conv_valid_i <= 0;
    @(posedge clk_i);
    chk(sample_valid_o, 1'b1);
    chk(sample_word_out_o, exp);
  endtask

  task automatic pop();
    stall <= 0;
    @(posedge clk_i);
    stall <= 1;
    @(posedge clk_i);
  endtask

  function automatic logic [9:0] fmt(input logic [2:0] c, input logic [9:0] x);
    if (c[2]) return x ^ {c[1], {9{c[0]}}};
    return {c[1], PATTERN_LOW ^ {9{c[0]}}};
  endfunction

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: whole sequence needs well under 2000 cycles
  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end

  initial begin
    logic [2:0] c;
    logic [9:0] x;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, CTRL_OFFSET, 0, 4'hf);
    chk(q, 32'h4);
    wb(0, 8'h0c, 0, 4'hf);
    chk(q, 32'h0);
    wb(1, CTRL_OFFSET, 32'h3, 4'he);
    wb(0, CTRL_OFFSET, 0, 4'hf);
    chk(q, 32'h4);
    wb(0, STAT_OFFSET, 0, 4'hf);
    chk(q[3], 1'b1);
    chk(conv_ready_o, 1'b0);
    output_enable_n_i <= 0;
    repeat (4) @(posedge clk_i);
    chk(sample_word_oe_o, 1'b1);
    output_enable_n_i <= 1;
    repeat (4) @(posedge clk_i);
    chk(sample_word_oe_o, 1'b0);
    // supplies taken as settled from here on
    chip_enable_n_i <= 0;
    repeat (5) @(posedge clk_i);
    wb(0, STAT_OFFSET, 0, 4'hf);
    chk(q[0], 1'b1);
    push(10'h001, 10'h001);
    chk(sample_unusable_o, 1'b1);
    pop();
    repeat (30) @(posedge clk_i);
    wb(0, STAT_OFFSET, 0, 4'hf);
    chk(q[2:0], 3'h4);
    cal_restart_i <= 1;
    repeat (6) @(posedge clk_i);
    wb(0, STAT_OFFSET, 0, 4'hf);
    chk(q[0], 1'b1);
    repeat (30) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      c = (i < 8) ? i[2:0] : 3'h4;
      x = (i == 8) ? 10'h3ff : (i == 9) ? 10'h000 : 10'h200;
      wb(1, CTRL_OFFSET, {29'h0, c}, 4'h1);
      push(x, fmt(c, x));
      chk(sample_low_unreliable_o, 1'b0);
      wb(0, WORD_OFFSET, 0, 4'hf);
      chk(q, {22'h0, fmt(c, x)});
      pop();
    end
    clr <= 1;
    feed <= 1;
    conv_valid_i <= 1;
    @(posedge clk_i);
    clr <= 0;
    repeat (8) @(posedge clk_i);
    chk(acc_n, 2);
    stall <= 0;
    repeat (5) @(posedge clk_i);
    busy_n = 0;
    // periodic pulse with a second fall inside the window
    cal_pulse_i <= 1;
    repeat (4) @(posedge clk_i);
    cal_pulse_i <= 0;
    repeat (3) @(posedge clk_i);
    cal_pulse_i <= 1;
    repeat (2) @(posedge clk_i);
    cal_pulse_i <= 0;
    repeat (30) @(posedge clk_i);
    feed <= 0;
    conv_valid_i <= 0;
    repeat (4) @(posedge clk_i);
    chk(busy_n, 4);
    chk(max_run_q, 5);
    chk(taken_q, acc_n + 4);
    chk(sample_valid_o, 1'b0);
    chip_enable_n_i <= 1;
    repeat (4) @(posedge clk_i);
    chk(conv_ready_o, 1'b0);
    give_verdict();
  end
endmodule

/* File: core/acf_buffer.sv */
`timescale 1ns/10ps
module acf_buffer import acf_pkg::*; #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } acf_buf_state_type;

  acf_buf_state_type st_q;
  acf_buf_state_type st_d;
  logic push;
  logic pop;

  // Honest flags: full stalls the writer, empty hides data
  assign in_ready_o = (st_q.count != CNT_W'(DEPTH));
  assign out_valid_o = (st_q.count != '0);
  assign out_data_o = st_q.mem[st_q.rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Circular pointers, count tracks occupancy
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_ptr] = in_data_i;
      st_d.wr_ptr = (st_q.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = (st_q.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* File: core/acf_pkg.sv */
package acf_pkg;

  // Sample word layout
  localparam int WORD_WIDTH = 10;
  localparam int LOW_BITS = 9;
  localparam int MSB_POS = 9;
  localparam logic [8:0] PATTERN_LOW = 9'h155;

  // Register bus layout
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] WORD_OFFSET = 8'h08;

  // Control register fields and reset value
  localparam int CTRL_LOW_INVERT_POS = 0;
  localparam int CTRL_MSB_INVERT_POS = 1;
  localparam int CTRL_PSEL_POS = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // Status register fields
  localparam int STAT_START_POS = 0;
  localparam int STAT_PER_POS = 1;
  localparam int STAT_CALD_POS = 2;
  localparam int STAT_STBY_POS = 3;
  localparam int STAT_FREEZE_POS = 4;

  // Calibration timing in sample clocks
  localparam int STARTUP_CYCLES_DEF = 33000;
  localparam logic [3:0] PER_BUSY_LAST = 4'h4;
  localparam logic [3:0] FREEZE_FIRST = 4'h8;
  localparam logic [3:0] PER_LAST = 4'hb;

  // Pin synchroniser reset levels: restart, enable_n, output_enable_n, cal
  localparam logic [3:0] PIN_RESET = 4'h6;

  typedef enum logic [1:0] {
    CAL_NEVER,
    CAL_RUN,
    CAL_DONE
  } acf_cal_state_type;

endpackage

/* File: core/acf_sync.sv */
`timescale 1ns/10ps
module acf_sync import acf_pkg::*; #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } acf_sync_state_type;

  acf_sync_state_type st_q;
  acf_sync_state_type st_d;

  // Two stages; only the second is visible
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= {RESET_VAL, RESET_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;

endmodule

/* File: core/acf_top.sv */
// Summary of operation
// RL1 - Normal mode outputs straight binary conversion code
// RL2 - Invert bits 0-8 and bit 9 separately
// RL3 - Pattern select low gives fixed alternating pattern
// RL4 - Restart rise or enable fall starts calibration
// RL5 - Startup calibration lasts about 33000 clocks, unusable
// RL6 - Host triggers calibration only after supplies settle
// RL7 - Never calibrated: only upper five bits trusted
// RL8 - Calibration pulse fall seen on clock edge
// RL9 - Comparator busy four clocks, no conversions
// RL10 - Seven clocks later, previous word held four clocks
// RL11 - Host pulses calibration input at regular intervals
// RL12 - Host derives calibration pulse from sync signal
// RL13 - Enable low active, high standby
// RL14 - Output enable low drives data, high releases
// RL15 - Calibration pulse during calibration is ignored
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module acf_top import acf_pkg::*; #(
  parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device pins, asynchronous
  input wire logic cal_restart_i,
  input wire logic chip_enable_n_i,
  input wire logic output_enable_n_i,
  input wire logic cal_pulse_i,
  // Raw conversion results, same clock
  input wire logic conv_valid_i,
  input wire logic [WORD_WIDTH-1:0] conv_code_i,
  output logic conv_ready_o,
  output logic comparator_busy_o,
  // Formatted sample stream
  output logic [WORD_WIDTH-1:0] sample_word_out_o,
  output logic sample_word_oe_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  output logic sample_unusable_o,
  output logic sample_low_unreliable_o
);

  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam int BUF_W = WORD_WIDTH + 2;

  typedef struct packed {
    acf_cal_state_type cal_st;
    logic [CNT_W-1:0] cal_cnt;
    logic [3:0] per_cnt;
    logic restart_prev;
    logic ce_n_prev;
    logic cal_prev;
    logic [2:0] ctrl;
    logic [WORD_WIDTH-1:0] last_word;
    logic ack;
    logic [31:0] rdata;
  } acf_top_state_type;

  acf_top_state_type st_q;
  acf_top_state_type st_d;

  logic [3:0] pins_s;
  logic restart_s;
  logic ce_n_s;
  logic oe_n_s;
  logic cal_s;
  logic active;
  logic startup_trig;
  logic cal_fall;
  logic per_start;
  logic comp_busy;
  logic freeze;
  logic buf_ready;
  logic push;
  logic conv_fire;
  logic [WORD_WIDTH-1:0] fmt_word;
  logic [WORD_WIDTH-1:0] push_word;
  logic [BUF_W-1:0] buf_out;
  logic wb_req;
  logic [31:0] rd_mux;

  // All pins cross into the sample clock before use
  acf_sync #(
    .WIDTH(4),
    .RESET_VAL(PIN_RESET)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({cal_restart_i, chip_enable_n_i, output_enable_n_i, cal_pulse_i}),
    .sync_o(pins_s)
  );

  assign restart_s = pins_s[3];
  assign ce_n_s = pins_s[2];
  assign oe_n_s = pins_s[1];
  assign cal_s = pins_s[0];

  // RL13 - standby gating
  assign active = ~ce_n_s;

  // RL4 - startup triggers
  assign startup_trig = (restart_s & ~st_q.restart_prev) | (~ce_n_s & st_q.ce_n_prev);

  // RL8 - high then low on consecutive edges
  assign cal_fall = st_q.cal_prev & ~cal_s;

  // RL15 - ignored while any calibration runs
  assign per_start = cal_fall & active & (st_q.per_cnt == '0) & (st_q.cal_st != CAL_RUN) & ~startup_trig;

  // RL9 - comparator taken for four clocks
  assign comp_busy = (st_q.per_cnt != '0) && (st_q.per_cnt <= PER_BUSY_LAST);

  // RL10 - hold window starts seven clocks after detection
  assign freeze = (st_q.per_cnt >= FREEZE_FIRST);

  // RL1 RL2 RL3 - output coding, inversion and test pattern
  always_comb begin
    if (!st_q.ctrl[CTRL_PSEL_POS]) begin
      fmt_word = {st_q.ctrl[CTRL_MSB_INVERT_POS], PATTERN_LOW ^ {LOW_BITS{st_q.ctrl[CTRL_LOW_INVERT_POS]}}};
    end else begin
      fmt_word = {conv_code_i[MSB_POS] ^ st_q.ctrl[CTRL_MSB_INVERT_POS],
                  conv_code_i[LOW_BITS-1:0] ^ {LOW_BITS{st_q.ctrl[CTRL_LOW_INVERT_POS]}}};
    end
  end

  // Samples arriving during a busy or hold clock are lost
  assign conv_ready_o = active & ~comp_busy & ~freeze & buf_ready;
  assign conv_fire = conv_valid_i & conv_ready_o;

  // RL10 - repeat previous word during hold
  assign push = freeze ? (active & buf_ready) : conv_fire;
  assign push_word = freeze ? st_q.last_word : fmt_word;

  // Two-entry buffer absorbs a receiver stall
  acf_buffer #(
    .WIDTH(BUF_W),
    .DEPTH(2)
  ) u_buffer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(buf_ready),
    // RL5 RL7 - quality flags travel with each word
    .in_data_i({st_q.cal_st == CAL_RUN, st_q.cal_st == CAL_NEVER, push_word}),
    .out_valid_o(sample_valid_o),
    .out_ready_i(sample_ready_i),
    .out_data_o(buf_out)
  );

  assign sample_word_out_o = buf_out[WORD_WIDTH-1:0];
  assign sample_low_unreliable_o = buf_out[WORD_WIDTH];
  assign sample_unusable_o = buf_out[WORD_WIDTH+1];
  // RL14 - drive only while output enable low
  assign sample_word_oe_o = ~oe_n_s;
  assign comparator_busy_o = comp_busy;

  // Register read mux; unmapped reads give zero
  assign wb_req = wb_cyc_i & wb_stb_i & ~st_q.ack;
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      CTRL_OFFSET: rd_mux[2:0] = st_q.ctrl;
      STAT_OFFSET: begin
        rd_mux[STAT_START_POS] = (st_q.cal_st == CAL_RUN);
        rd_mux[STAT_PER_POS] = (st_q.per_cnt != '0);
        rd_mux[STAT_CALD_POS] = (st_q.cal_st == CAL_DONE);
        rd_mux[STAT_STBY_POS] = ce_n_s;
        rd_mux[STAT_FREEZE_POS] = freeze;
      end
      WORD_OFFSET: rd_mux[WORD_WIDTH-1:0] = st_q.last_word;
      default: rd_mux = '0;
    endcase
  end

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.restart_prev = restart_s;
    st_d.ce_n_prev = ce_n_s;
    st_d.cal_prev = cal_s;
    st_d.ack = wb_req;
    if (wb_req) begin
      st_d.rdata = rd_mux;
    end
    if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CTRL_OFFSET)) begin
      st_d.ctrl = wb_dat_i[2:0];
    end
    // RL4 RL5 - startup calibration counter, retrigger restarts it
    if (startup_trig) begin
      st_d.cal_st = CAL_RUN;
      st_d.cal_cnt = CNT_W'(STARTUP_CYCLES - 1);
    end else if (st_q.cal_st == CAL_RUN) begin
      if (st_q.cal_cnt == '0) begin
        st_d.cal_st = CAL_DONE;
      end else begin
        st_d.cal_cnt = st_q.cal_cnt - 1'b1;
      end
    end
    // RL8 RL9 RL10 - periodic calibration sequence
    if (per_start) begin
      st_d.per_cnt = 4'h1;
    end else if (st_q.per_cnt == PER_LAST) begin
      st_d.per_cnt = '0;
    end else if (st_q.per_cnt != '0) begin
      st_d.per_cnt = st_q.per_cnt + 4'h1;
    end
    if (push) begin
      st_d.last_word = push_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '{cal_st: CAL_NEVER, ctrl: CTRL_RESET, restart_prev: 1'b0, ce_n_prev: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_per_detect;
    cal_fall && active && st_q.per_cnt == '0 && st_q.cal_st != CAL_RUN && !startup_trig |=> st_q.per_cnt == 4'h1;
  endproperty
  a_per_detect: assert property (p_per_detect) else $error("calibration fall not started"); // RL8

  property p_comp_busy;
    st_q.per_cnt == 4'h1 |-> comp_busy [*4] ##1 !comp_busy;
  endproperty
  a_comp_busy: assert property (p_comp_busy) else $error("comparator busy span wrong"); // RL9

  property p_no_conv;
    comp_busy |-> !conv_ready_o;
  endproperty
  a_no_conv: assert property (p_no_conv) else $error("conversion taken while busy"); // RL9

  property p_freeze;
    st_q.per_cnt == 4'h1 |-> ##7 freeze [*4] ##1 !freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("hold window misplaced"); // RL10

  property p_hold_word;
    push && freeze |-> push_word == st_q.last_word ##1 st_q.last_word == $past(st_q.last_word);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("hold word changed"); // RL10

  property p_ignore;
    st_q.per_cnt != '0 && st_q.per_cnt != PER_LAST |=> st_q.per_cnt != 4'h1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("calibration restarted mid run"); // RL15

  property p_startup;
    startup_trig |=> (st_q.cal_st == CAL_RUN) [*8];
  endproperty
  a_startup: assert property (p_startup) else $error("startup calibration not running"); // RL4

  property p_unusable;
    push && st_q.cal_st == CAL_RUN && !sample_valid_o |=> sample_valid_o && sample_unusable_o;
  endproperty
  a_unusable: assert property (p_unusable) else $error("word during calibration not marked"); // RL5

  property p_pattern;
    conv_fire && !st_q.ctrl[CTRL_PSEL_POS]
      |-> push_word[LOW_BITS-1:0] == (PATTERN_LOW ^ {LOW_BITS{st_q.ctrl[CTRL_LOW_INVERT_POS]}})
          && push_word[MSB_POS] == st_q.ctrl[CTRL_MSB_INVERT_POS];
  endproperty
  a_pattern: assert property (p_pattern) else $error("test pattern wrong"); // RL3

  property p_invert;
    conv_fire && st_q.ctrl[CTRL_PSEL_POS] |-> (push_word ^ conv_code_i)
      == {st_q.ctrl[CTRL_MSB_INVERT_POS], {LOW_BITS{st_q.ctrl[CTRL_LOW_INVERT_POS]}}};
  endproperty
  a_invert: assert property (p_invert) else $error("inversion wrong"); // RL2

  property p_standby;
    ce_n_s |-> !conv_ready_o && !push;
  endproperty
  a_standby: assert property (p_standby) else $error("activity in standby"); // RL13

  property p_oe;
    !$past(rst_i) && !$past(rst_i, 2) |-> sample_word_oe_o == !$past(output_enable_n_i, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable not driven"); // RL14

endmodule
